// file: core/tim_chan_cfg.svh
// Notes on behaviour
// - a channel is input capture when its function bit is 0, compare when 1.
// - function-select bits of absent channels ignore writes and read back as zero.
// - the compare-force register always reads as zero.
// - a force bit performs the channel's compare action at once, no flag set.
// - force and real match together: force wins, the flag stays clear.
// - a channel 7 event overrides compare actions of masked channels 7 to 0.
// - on a channel 7 event, masked channels take the linked data bit.
// - unmasked channels ignore the linked data bit on a channel 7 event.
// - linked data reaches a pin only if compare mode and not disconnected.
// - without channel 7 the mask and data registers read zero, ignore writes.
`ifndef TIM_CHAN_CFG_SVH
`define TIM_CHAN_CFG_SVH

// ****************************************
// register indices, byte address is four times the index
// ****************************************
`define TCC_IDX_W 6
`define TCC_IDX_FUNC_SEL 6'h00
`define TCC_IDX_FORCE 6'h01
`define TCC_IDX_LINK_MASK 6'h02
`define TCC_IDX_LINK_DATA 6'h03
`define TCC_IDX_IRQ_STATUS 6'h10
`define TCC_IDX_IRQ_MASK 6'h11

// ****************************************
// reset values and fields
// ****************************************
`define TCC_FUNC_SEL_RST 8'h00
`define TCC_LINK_MASK_RST 8'h00
`define TCC_LINK_DATA_RST 8'h00
`define TCC_PORT_RST 8'h00
`define TCC_IRQ_W 3
`define TCC_IRQ_RST 3'h0
`define TCC_IRQ_LINKED 0
`define TCC_IRQ_FORCED 1
`define TCC_IRQ_MATCH 2
`define TCC_CHANNELS_PRESENT 8'hFF

// ****************************************
// bus answers
// ****************************************
`define TCC_RESP_OKAY 2'h0
`define TCC_RESP_SLVERR 2'h2

`endif

// file: core/tim_chan_pkg.sv
package tim_chan_pkg;

    // ****************************************
    // programmed compare action per channel
    // ****************************************
    typedef enum logic [1:0] {
        ACT_NONE = 2'b00,
        ACT_TOGGLE = 2'b01,
        ACT_CLEAR = 2'b10,
        ACT_SET = 2'b11
    } action_e;

    // ****************************************
    // timer-side events from counter and compare logic
    // ****************************************
    typedef struct packed {
        logic [7:0] compareMatch;
        logic counterOverflow;
        logic channel7ToggleOnOverflow;
    } timer_events_s;

    // ****************************************
    // per-channel control seen by the output logic
    // ****************************************
    typedef struct packed {
        logic [7:0] functionSel;
        logic [7:0] pinDisconnect;
        logic [7:0] forcePulse;
        logic [7:0] compareMatch;
        logic [7:0] linkedMask;
        logic [7:0] linkedData;
        logic channel7Event;
    } chan_ctrl_s;

endpackage : tim_chan_pkg

// file: core/chan_output_logic.sv
module chan_output_logic (
    // channel control
    input wire tim_chan_pkg::chan_ctrl_s ctrl,
    input wire logic [15:0] actionSel,
    input wire logic [7:0] portNow,
    // results
    output logic [7:0] nextPort,
    output logic [7:0] nextFlag
);
    import tim_chan_pkg::*;

    genvar i;
    generate
        for (i = 0; i < 8; i++) begin : g_chan
            logic outMode;
            logic linked;
            logic fire;
            assign outMode = ctrl.functionSel[i] & ~ctrl.pinDisconnect[i];
            assign linked = ctrl.channel7Event & ctrl.linkedMask[i] & outMode;
            assign fire = (ctrl.forcePulse[i] | ctrl.compareMatch[i]) & outMode;

            always_comb begin
                nextPort[i] = portNow[i];
                if (linked) begin
                    // channel 7 wins over the channel's own action
                    nextPort[i] = ctrl.linkedData[i];
                end else if (fire) begin
                    case (action_e'(actionSel[2*i +: 2]))
                        ACT_TOGGLE: nextPort[i] = ~portNow[i];
                        ACT_CLEAR: nextPort[i] = 1'b0;
                        ACT_SET: nextPort[i] = 1'b1;
                        default: nextPort[i] = portNow[i];
                    endcase
                end
            end

            // a forced action never raises the flag, even with a real match
            assign nextFlag[i] = ctrl.compareMatch[i] & ctrl.functionSel[i] & ~ctrl.forcePulse[i];
        end
    endgenerate

endmodule : chan_output_logic

// file: core/timer_channel_ctrl.sv
`include "tim_chan_cfg.svh"

module timer_channel_ctrl #(
    parameter logic [7:0] CHANNELS_PRESENT = `TCC_CHANNELS_PRESENT,
    parameter int ADDR_W = 8
) (
    // clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // axi4-lite write address
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read address
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // axi4-lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // timer side
    input wire tim_chan_pkg::timer_events_s timerEvents,
    input wire logic [7:0] pinDisconnect,
    input wire logic [15:0] outputAction,
    // timer port
    output logic [7:0] portOut,
    output logic [7:0] portDrive,
    output logic [7:0] compareFlagSet,
    output logic irq
);
    import tim_chan_pkg::*;

    // ****************************************
    // declarations
    // ****************************************
    localparam bit CH7_PRESENT = CHANNELS_PRESENT[7];
    localparam logic [7:0] LINK_KEEP = CH7_PRESENT ? 8'hFF : 8'h00;

    logic [7:0] functionSel;
    logic [7:0] linkedMask;
    logic [7:0] linkedData;
    logic [7:0] forcePulse;
    logic [`TCC_IRQ_W-1:0] irqStatus;
    logic [`TCC_IRQ_W-1:0] irqMask;

    logic awHeld;
    logic wHeld;
    logic [`TCC_IDX_W-1:0] awIdx;
    logic [7:0] wByte;
    logic wLane0;
    logic writeNow;
    logic [`TCC_IDX_W-1:0] arIdx;
    logic readTake;
    logic writeFunc;
    logic writeForce;
    logic writeLinkMask;
    logic writeLinkData;
    logic writeIrqMask;
    logic awMapped;

    logic channel7Event;
    logic [7:0] nextPort;
    logic [7:0] nextFlag;
    logic [`TCC_IRQ_W-1:0] irqEvents;
    logic [`TCC_IRQ_W-1:0] irqClear;
    logic [`TCC_IRQ_W-1:0] next_irqStatus;
    chan_ctrl_s chanCtrl;

    // ****************************************
    // write channel
    // ****************************************
    assign writeNow = awHeld & wHeld & ~s_axi_bvalid;
    assign awMapped = (awIdx == `TCC_IDX_FUNC_SEL) || (awIdx == `TCC_IDX_FORCE) ||
        (awIdx == `TCC_IDX_LINK_MASK) || (awIdx == `TCC_IDX_LINK_DATA) ||
        (awIdx == `TCC_IDX_IRQ_STATUS) || (awIdx == `TCC_IDX_IRQ_MASK);
    assign writeFunc = writeNow & wLane0 & (awIdx == `TCC_IDX_FUNC_SEL);
    assign writeForce = writeNow & wLane0 & (awIdx == `TCC_IDX_FORCE);
    assign writeLinkMask = writeNow & wLane0 & (awIdx == `TCC_IDX_LINK_MASK);
    assign writeLinkData = writeNow & wLane0 & (awIdx == `TCC_IDX_LINK_DATA);
    assign writeIrqMask = writeNow & wLane0 & (awIdx == `TCC_IDX_IRQ_MASK);

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            s_axi_awready <= 1'b1;
            awHeld <= 1'b0;
            awIdx <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            s_axi_awready <= 1'b0;
            awHeld <= 1'b1;
            awIdx <= s_axi_awaddr[`TCC_IDX_W+1:2];
        end else if (writeNow) begin
            awHeld <= 1'b0;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_awready <= 1'b1;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            s_axi_wready <= 1'b1;
            wHeld <= 1'b0;
            wByte <= 8'h00;
            wLane0 <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            s_axi_wready <= 1'b0;
            wHeld <= 1'b1;
            wByte <= s_axi_wdata[7:0];
            wLane0 <= s_axi_wstrb[0];
        end else if (writeNow) begin
            wHeld <= 1'b0;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_wready <= 1'b1;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `TCC_RESP_OKAY;
        end else if (writeNow) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= awMapped ? `TCC_RESP_OKAY : `TCC_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            functionSel <= `TCC_FUNC_SEL_RST;
        end else if (writeFunc) begin
            functionSel <= wByte & CHANNELS_PRESENT;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            linkedMask <= `TCC_LINK_MASK_RST;
        end else if (writeLinkMask) begin
            linkedMask <= wByte & LINK_KEEP;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            linkedData <= `TCC_LINK_DATA_RST;
        end else if (writeLinkData) begin
            linkedData <= wByte & LINK_KEEP;
        end
    end

    // force bits live for exactly the cycle after the write
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            forcePulse <= 8'h00;
        end else begin
            forcePulse <= writeForce ? (wByte & CHANNELS_PRESENT) : 8'h00;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            irqMask <= `TCC_IRQ_RST;
        end else if (writeIrqMask) begin
            irqMask <= wByte[`TCC_IRQ_W-1:0];
        end
    end

    // ****************************************
    // read channel
    // ****************************************
    assign readTake = s_axi_arvalid & s_axi_arready;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `TCC_RESP_OKAY;
            arIdx <= '0;
        end else if (readTake) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            arIdx <= s_axi_araddr[`TCC_IDX_W+1:2];
            s_axi_rresp <= `TCC_RESP_OKAY;
            case (s_axi_araddr[`TCC_IDX_W+1:2])
                `TCC_IDX_FUNC_SEL: s_axi_rdata <= {24'h000000, functionSel};
                `TCC_IDX_FORCE: s_axi_rdata <= 32'h0000_0000;
                `TCC_IDX_LINK_MASK: s_axi_rdata <= {24'h000000, linkedMask};
                `TCC_IDX_LINK_DATA: s_axi_rdata <= {24'h000000, linkedData};
                `TCC_IDX_IRQ_STATUS: s_axi_rdata <= {29'h0000_0000, irqStatus};
                `TCC_IDX_IRQ_MASK: s_axi_rdata <= {29'h0000_0000, irqMask};
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= `TCC_RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // ****************************************
    // channel output logic
    // ****************************************
    // a forced channel 7 compare counts as a successful one
    assign channel7Event = CH7_PRESENT & ((functionSel[7] & ~pinDisconnect[7] &
        (timerEvents.compareMatch[7] | forcePulse[7])) |
        (timerEvents.counterOverflow & timerEvents.channel7ToggleOnOverflow));

    assign chanCtrl = '{
        functionSel: functionSel,
        pinDisconnect: pinDisconnect,
        forcePulse: forcePulse,
        compareMatch: timerEvents.compareMatch & CHANNELS_PRESENT,
        linkedMask: linkedMask,
        linkedData: linkedData,
        channel7Event: channel7Event
    };

    chan_output_logic u_chan_output_logic (
        .ctrl(chanCtrl),
        .actionSel(outputAction),
        .portNow(portOut),
        .nextPort(nextPort),
        .nextFlag(nextFlag)
    );

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            portOut <= `TCC_PORT_RST;
            portDrive <= 8'h00;
        end else begin
            portOut <= nextPort & CHANNELS_PRESENT;
            portDrive <= functionSel & ~pinDisconnect;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            compareFlagSet <= 8'h00;
        end else begin
            compareFlagSet <= nextFlag;
        end
    end

    // ****************************************
    // interrupt
    // ****************************************
    assign irqEvents[`TCC_IRQ_LINKED] = channel7Event;
    assign irqEvents[`TCC_IRQ_FORCED] = |forcePulse;
    assign irqEvents[`TCC_IRQ_MATCH] = |nextFlag;
    assign irqClear = (readTake && s_axi_araddr[`TCC_IDX_W+1:2] == `TCC_IDX_IRQ_STATUS) ? '1 : '0;
    // a new event in the clearing read's cycle survives the clear
    assign next_irqStatus = (irqStatus & ~irqClear) | irqEvents;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            irqStatus <= `TCC_IRQ_RST;
            irq <= 1'b0;
        end else begin
            irqStatus <= next_irqStatus;
            irq <= |(next_irqStatus & irqMask);
        end
    end

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);

    logic [7:0] outMode;
    logic [7:0] linkSel;
    assign outMode = functionSel & ~pinDisconnect;
    assign linkSel = channel7Event ? (linkedMask & outMode) : 8'h00;

    absent_bits_zero_a: assert property ((functionSel & ~CHANNELS_PRESENT) == 8'h00)
        else $error("absent channel select bit set");

    force_reads_zero_a: assert property (s_axi_rvalid && arIdx == `TCC_IDX_FORCE |-> s_axi_rdata == 0)
        else $error("force register read nonzero");

    force_pulse_once_a: assert property (forcePulse != 8'h00 |=> forcePulse == 8'h00)
        else $error("force bit held longer than one cycle");

    force_write_pulse_a: assert property (writeForce && wByte[0] && CHANNELS_PRESENT[0] |=> forcePulse[0])
        else $error("force write produced no pulse");

    force_no_flag_a: assert property (forcePulse != 8'h00 |=> (compareFlagSet & $past(forcePulse)) == 8'h00)
        else $error("flag set by forced action");

    force_set_action_a: assert property (forcePulse[0] && outMode[0] && !linkSel[0] &&
        outputAction[1:0] == ACT_SET |=> portOut[0])
        else $error("forced set action not performed");

    linked_transfer_a: assert property (channel7Event |=>
        ((portOut ^ $past(linkedData)) & $past(linkSel) & CHANNELS_PRESENT) == 8'h00)
        else $error("linked data not transferred");

    unmasked_kept_a: assert property (channel7Event && (forcePulse | timerEvents.compareMatch) == 8'h00 |=>
        ((portOut ^ $past(portOut)) & ~$past(linkedMask)) == 8'h00)
        else $error("unmasked pin changed on channel 7 event");

    capture_pins_hold_a: assert property (1'b1 |=> ((portOut ^ $past(portOut)) & ~$past(outMode)) == 8'h00)
        else $error("pin moved while not in compare mode");

    reserved_linked_a: assert property (!CH7_PRESENT |-> linkedMask == 8'h00 && linkedData == 8'h00)
        else $error("reserved linked register not zero");

    flag_from_match_a: assert property (timerEvents.compareMatch[1] && functionSel[1] && !forcePulse[1] &&
        CHANNELS_PRESENT[1] |=> compareFlagSet[1])
        else $error("compare match raised no flag");

    force_over_match_a: assert property (forcePulse[2] && timerEvents.compareMatch[2] && outMode[2] &&
        !linkSel[2] && outputAction[5:4] == ACT_TOGGLE |=> portOut[2] != $past(portOut[2]) && !compareFlagSet[2])
        else $error("forced action lost against a real match");

    flag_needs_compare_a: assert property (compareFlagSet != 8'h00 |-> (compareFlagSet & ~$past(functionSel)) == 8'h00)
        else $error("flag raised on a capture channel");

    force_write_c: cover property (writeForce && wByte != 8'h00);
    linked_overflow_c: cover property (channel7Event && timerEvents.counterOverflow);
    linked_event_c: cover property (channel7Event && linkSel != 8'h00);
    force_with_match_c: cover property ((forcePulse & timerEvents.compareMatch) != 8'h00);
    irq_raised_c: cover property (!irq ##1 irq);

endmodule : timer_channel_ctrl

// file: sim/timer_channel_ctrl_tb.sv
`include "tim_chan_cfg.svh"

`define CHK(nm, e, s) begin comparisons++; if ((s) !== (e)) begin \
    $display("[FAIL] %s expected %h seen %h", nm, e, s); failCount++; end end

module timer_channel_ctrl_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import tim_chan_pkg::*;

    // ********************
    // signals and models
    // ********************
    logic clock, reset_n, awValid, awReady, wValid, wReady, bValid, bReady;
    logic arValid, arReady, rValid, rReady, irq, portLook;
    logic [7:0] awAddr, arAddr, pinDisconnect, portOut, portDrive, compareFlagSet;
    logic [31:0] wData, rData;
    logic [1:0] bResp, rResp;
    logic [15:0] outputAction, oaM;
    timer_events_s timerEvents;
    logic [7:0] fsM, pdM, maskM, dataM, portM;
    logic [2:0] statusM;
    logic [33:0] ex;
    logic [33:0] bQ[$], rQ[$], pQ[$];
    int failCount, comparisons, cycles;

    timer_channel_ctrl dut_u (
        .clock(clock), .reset_n(reset_n),
        .s_axi_awaddr(awAddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
        .s_axi_wdata(wData), .s_axi_wstrb(4'hF), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
        .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
        .s_axi_araddr(arAddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
        .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
        .timerEvents(timerEvents), .pinDisconnect(pinDisconnect), .outputAction(outputAction),
        .portOut(portOut), .portDrive(portDrive), .compareFlagSet(compareFlagSet), .irq(irq)
    );

    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    // ********************
    // expected port after a compare action
    // ********************
    function automatic logic [7:0] act(input logic [7:0] p, input logic [15:0] a, input logic [7:0] hit);
        for (int i = 0; i < 8; i++) begin
            if (hit[i]) begin
                case (a[2*i+:2])
                    ACT_TOGGLE: p[i] = ~p[i];
                    ACT_CLEAR: p[i] = 1'b0;
                    ACT_SET: p[i] = 1'b1;
                    default: p[i] = p[i];
                endcase
            end
        end
        return p;
    endfunction : act

    // ********************
    // bus master, m is a match presented so it meets the force pulse
    // ********************
    task automatic axiWrite(input logic [5:0] ix, input logic [31:0] d, input logic [1:0] r,
                            input logic [7:0] m);
        logic aDone, dDone;
        aDone = 1'b0;
        dDone = 1'b0;
        bQ.push_back({32'h0, r});
        awAddr <= {ix, 2'b00};
        wData <= d;
        awValid <= 1'b1;
        wValid <= 1'b1;
        while (!(aDone && dDone)) begin
            @(posedge clock);
            if (awValid && awReady) begin
                aDone = 1'b1;
                awValid <= 1'b0;
            end
            if (wValid && wReady) begin
                dDone = 1'b1;
                wValid <= 1'b0;
            end
        end
        bReady <= 1'b1;
        @(posedge clock);
        timerEvents.compareMatch <= m;
        do begin
            @(posedge clock);
            timerEvents.compareMatch <= 8'h00;
        end while (!bValid);
        bReady <= 1'b0;
    endtask : axiWrite

    task automatic axiRead(input logic [5:0] ix, input logic [33:0] e);
        rQ.push_back(e);
        arAddr <= {ix, 2'b00};
        arValid <= 1'b1;
        do @(posedge clock); while (!arReady);
        arValid <= 1'b0;
        rReady <= 1'b1;
        do @(posedge clock); while (!rValid);
        rReady <= 1'b0;
    endtask : axiRead

    // note what the port side must show one cycle later
    task automatic look(input logic [7:0] p, input logic [7:0] f, input logic q);
        pQ.push_back({9'h0, q, fsM & ~pdM, f, p});
        portLook <= 1'b1;
        @(posedge clock);
        portLook <= 1'b0;
        @(posedge clock);
    endtask : look

    task automatic fire(input logic [7:0] m, input logic ovf, input logic tog);
        logic [7:0] elig, own;
        logic ev;
        elig = maskM & fsM & ~pdM;
        ev = (fsM[7] & ~pdM[7] & m[7]) | (ovf & tog);
        own = act(portM, oaM, m & fsM);
        portM = ev ? ((own & ~elig) | (dataM & elig)) : own;
        statusM = statusM | {|(m & fsM), 1'b0, ev};
        timerEvents.compareMatch <= m;
        timerEvents.counterOverflow <= ovf;
        timerEvents.channel7ToggleOnOverflow <= tog;
        @(posedge clock);
        timerEvents.compareMatch <= 8'h00;
        timerEvents.counterOverflow <= 1'b0;
        look(portM, m & fsM, 1'b0);
    endtask : fire

    task automatic testDone();
        $display("comparisons %0d mismatches %0d", comparisons, failCount);
        if (failCount == 0 && comparisons > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : testDone

    // ********************
    // result watcher
    // ********************
    always @(posedge clock) begin
        if (bValid && bReady) begin
            ex = bQ.pop_front();
            `CHK("bresp", ex[1:0], bResp)
        end
        if (rValid && rReady) begin
            ex = rQ.pop_front();
            `CHK("read", ex, {rResp, rData})
        end
        if (portLook) begin
            ex = pQ.pop_front();
            `CHK("port", ex[24:0], {irq, portDrive, compareFlagSet, portOut})
        end
    end

    // a hung handshake ends here
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            failCount++;
            testDone();
        end
    end

    // ********************
    // tests
    // ********************
    initial begin
        void'($urandom(32'hA58CCBB4));
        {reset_n, awValid, wValid, bReady, arValid, rReady, portLook} = '0;
        {awAddr, arAddr, wData, pinDisconnect, outputAction, timerEvents} = '0;
        {fsM, pdM, maskM, dataM, portM, statusM, oaM} = '0;
        repeat (20) @(posedge clock);
        reset_n <= 1'b1;
        @(posedge clock);
        axiRead(`TCC_IDX_FUNC_SEL, 34'h0);
        axiRead(`TCC_IDX_FORCE, 34'h0);
        axiRead(`TCC_IDX_LINK_MASK, 34'h0);
        axiRead(`TCC_IDX_LINK_DATA, 34'h0);
        axiRead(`TCC_IDX_IRQ_STATUS, 34'h0);
        axiRead(`TCC_IDX_IRQ_MASK, 34'h0);
        axiRead(6'h20, {`TCC_RESP_SLVERR, 32'h0});
        axiWrite(6'h20, 32'hFF, `TCC_RESP_SLVERR, 8'h00);
        look(8'h00, 8'h00, 1'b0);
        fsM = 8'($urandom);
        axiWrite(`TCC_IDX_FUNC_SEL, {24'hFFFFFF, fsM}, `TCC_RESP_OKAY, 8'h00);
        axiRead(`TCC_IDX_FUNC_SEL, {`TCC_RESP_OKAY, 24'h0, fsM});
        $display("test registers done");

        fsM = 8'hFF;
        axiWrite(`TCC_IDX_FUNC_SEL, 32'hFF, `TCC_RESP_OKAY, 8'h00);
        for (int k = 0; k < 4; k++) begin
            oaM = {8{k[1:0]}};
            outputAction <= oaM;
            @(posedge clock);
            portM = act(portM, oaM, 8'hFF);
            statusM = statusM | 3'b011;
            axiWrite(`TCC_IDX_FORCE, 32'hFF, `TCC_RESP_OKAY, 8'h00);
            look(portM, 8'h00, 1'b0);
            look(portM, 8'h00, 1'b0);
            axiRead(`TCC_IDX_FORCE, 34'h0);
        end
        oaM = {8{ACT_TOGGLE}};
        outputAction <= oaM;
        @(posedge clock);
        portM = act(portM, oaM, 8'h3F);
        statusM = statusM | 3'b110;
        axiWrite(`TCC_IDX_FORCE, 32'h0F, `TCC_RESP_OKAY, 8'h3C);
        look(portM, 8'h30, 1'b0);
        $display("test force done");

        for (int n = 0; n < 3; n++) begin
            fsM = 8'($urandom) | 8'h80;
            pdM = 8'($urandom) & 8'h7F;
            maskM = 8'($urandom);
            dataM = 8'($urandom);
            for (int i = 0; i < 8; i++) oaM[2*i+:2] = (fsM[i] & ~pdM[i]) ? ACT_TOGGLE : ACT_NONE;
            pinDisconnect <= pdM;
            outputAction <= oaM;
            axiWrite(`TCC_IDX_FUNC_SEL, {24'h0, fsM}, `TCC_RESP_OKAY, 8'h00);
            axiWrite(`TCC_IDX_LINK_MASK, {24'h0, maskM}, `TCC_RESP_OKAY, 8'h00);
            axiWrite(`TCC_IDX_LINK_DATA, {24'h0, dataM}, `TCC_RESP_OKAY, 8'h00);
            axiRead(`TCC_IDX_LINK_MASK, {`TCC_RESP_OKAY, 24'h0, maskM});
            axiRead(`TCC_IDX_LINK_DATA, {`TCC_RESP_OKAY, 24'h0, dataM});
            fire(8'hFF, 1'b0, 1'b0);
            fire(8'h00, 1'b1, 1'b1);
            fire(8'h00, 1'b1, 1'b0);
        end
        $display("test linked output done");

        axiRead(`TCC_IDX_IRQ_STATUS, {31'h0, statusM});
        statusM = 3'h0;
        axiWrite(`TCC_IDX_IRQ_MASK, 32'h2, `TCC_RESP_OKAY, 8'h00);
        axiRead(`TCC_IDX_IRQ_MASK, 34'h2);
        fire(8'h7F, 1'b0, 1'b0);
        portM = act(portM, oaM, 8'h01);
        statusM = statusM | 3'b010;
        axiWrite(`TCC_IDX_FORCE, 32'h01, `TCC_RESP_OKAY, 8'h00);
        repeat (2) @(posedge clock);
        look(portM, 8'h00, 1'b1);
        axiRead(`TCC_IDX_IRQ_STATUS, {31'h0, statusM});
        repeat (2) @(posedge clock);
        look(portM, 8'h00, 1'b0);
        $display("test interrupt done");
        testDone();
    end
endmodule : timer_channel_ctrl_tb
